// [design/codec_core_defines.svh]
// Constants for the audio codec digital core
// Behaviour
// - Peak level is 6 bits, 1 dB steps
// - Peak held until read, read clears it
// - Master/slave pin sets ADC clock direction
// - Decimator oversamples 128 or 64
// - ADC channels share bit and frame clock
// - Three serial DAC inputs share clocks
// - Six attenuators with 1024 linear steps
// - Packed mode carries six channels one input
// - Replicate copies first pair to others
// - 192 kHz accepted on first pair only
// - Two's complement, 16/20/24 bit words
// - Clock scaler x2 default, x1 or x2/3
// - Scaler writes applied in first 3072 clocks
// - Interpolator 8x/4x/2x from rate code
// - ADC rate internal/512, or /256 if set
// - Reset pin restores register defaults
// - Init clears memories for 20 frames
// - 16-bit frame: addr, r/w, zero, data
// - Peak registers are read-only
`ifndef CODEC_CORE_DEFINES_SVH
`define CODEC_CORE_DEFINES_SVH
`define ADDR_DAC_CTRL1 4'h0
`define ADDR_DAC_CTRL2 4'h1
`define ADDR_DAC_VOL0 4'h2
`define ADDR_ADC_PEAK0 4'hA
`define ADDR_ADC_PEAK1 4'hB
`define ADDR_ADC_CTRL1 4'hC
`define ADDR_ADC_CTRL2 4'hD
`define ADDR_ADC_CTRL3 4'hE
`define FRAME_ADDR_HI 15
`define FRAME_RW_BIT 11
`define FRAME_ZERO_BIT 10
`define DAC_RATE_LO 0
`define DAC_WIDTH_LO 3
`define DAC_PACKED_BIT 5
`define DAC_REPL_BIT 1
`define ADC_RATE_BIT 6
`define ADC_WIDTH_LO 4
`define SCALER_LO 0
`define RESET_VOL 10'h3FF
`define RESET_CTRL 10'h000
`define SCALE_WINDOW 3072
`define INIT_FRAMES 20
`define PEAK_MIN 6'h3F
`define OSR_48K 128
`define OSR_96K 64
`endif

// [design/codec_core_pkg.sv]
// Types for the audio codec digital core
package codec_core_pkg;
  typedef enum logic [1:0] {RATE_48K, RATE_96K, RATE_192K, RATE_RSVD} dac_rate_type;
  typedef enum logic [1:0] {SCALE_X2, SCALE_X1, SCALE_X2_3, SCALE_RSVD} scaler_type;
  typedef enum {INIT_CLEAR, RUNNING} core_state_type;
endpackage

// [design/sample_buffer.sv]
// Two-entry valid/ready buffer for DAC sample words
`timescale 1ns/1ps
module sample_buffer
  import codec_core_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic inValid,
  output logic inReady,
  input wire logic [23:0] inData,
  input wire logic [2:0] inChan,
  output logic outValid,
  input wire logic outReady,
  output logic [23:0] outData,
  output logic [2:0] outChan
);
  logic [26:0] slot [0:1];
  logic rdPtr;
  logic wrPtr;
  logic [1:0] count;

  assign inReady = (count != 2'd2);
  assign outValid = (count != 2'd0);
  assign outData = slot[rdPtr][23:0];
  assign outChan = slot[rdPtr][26:24];

  always_ff @(posedge core_clk or negedge rst_n)
    if (!rst_n)
    begin
      slot[0] <= 27'h0;
      slot[1] <= 27'h0;
      wrPtr <= 1'b0;
    end
    else if (inValid && inReady)
    begin
      slot[wrPtr] <= {inChan, inData};
      wrPtr <= ~wrPtr;
    end

  always_ff @(posedge core_clk or negedge rst_n)
    if (!rst_n)
      rdPtr <= 1'b0;
    else if (outValid && outReady)
      rdPtr <= ~rdPtr;

  always_ff @(posedge core_clk or negedge rst_n)
    if (!rst_n)
      count <= 2'd0;
    else
      count <= count + 2'(inValid && inReady) - 2'(outValid && outReady);
endmodule

// [design/audio_codec_digital_core.sv]
// Digital core: control frames, clocking, DAC path and ADC peak detectors
`timescale 1ns/1ps
`include "codec_core_defines.svh"
module audio_codec_digital_core
  import codec_core_pkg::*;
(
  input wire logic core_clk,
  input wire logic powerdown_reset_n,
  input wire logic ctrlValid,
  input wire logic [15:0] ctrlFrame,
  output logic [9:0] ctrlReadData,
  output logic ctrlReadValid,
  input wire logic masterSelect_n,
  output logic adc_bit_clock_o,
  output logic adc_bit_clock_oe,
  input wire logic adc_bit_clock_i,
  output logic adc_frame_clock_o,
  output logic adc_frame_clock_oe,
  input wire logic adc_frame_clock_i,
  input wire logic adcSampleValid,
  input wire logic [23:0] adcLeft,
  input wire logic [23:0] adcRight,
  input wire logic dacWordValid,
  output logic dacWordReady,
  input wire logic [23:0] dacWord,
  input wire logic [2:0] dacWordChan,
  output logic dacOutValid,
  input wire logic dacOutReady,
  output logic [23:0] dacOutData,
  output logic [2:0] dacOutChan,
  output logic [9:0] dacOutGain,
  output logic [3:0] interpRatio,
  output logic [7:0] decimRatio,
  output logic [1:0] clockScale,
  output logic initBusy
);
  logic rst_n;
  assign rst_n = powerdown_reset_n;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Whole-dB attenuation from magnitude: 20log10(2)=6.02, so leading-zero count
  // times 6 plus a coarse mantissa step. Cheap, at most about 1 dB off.
  function automatic logic [5:0] mag_to_db(input logic [22:0] mag);
    logic [5:0] db;
    logic [22:0] m;
    integer lz;
    db = `PEAK_MIN;
    m = mag;
    lz = 23;
    for (int i = 0; i < 23; i++)
      if (m[i])
        lz = 22 - i;
    if (lz < 23)
    begin
      m = mag << lz;
      db = 6'(lz * 6);
      if (m[21:20] == 2'b00)
        db = 6'(lz * 6 + 5);
      else if (m[21:20] == 2'b01)
        db = 6'(lz * 6 + 3);
      else if (m[21:20] == 2'b10)
        db = 6'(lz * 6 + 2);
      if (lz >= 10)
        db = `PEAK_MIN;
    end
    return db;
  endfunction

  // Magnitude of a two's complement sample, negative full scale saturates
  function automatic logic [22:0] magnitude(input logic [23:0] s);
    logic [23:0] n;
    n = s[23] ? (~s + 24'h1) : s;
    return n[23] ? 23'h7FFFFF : n[22:0];
  endfunction

  // Keep the top bits of the chosen word width, zero the rest
  function automatic logic [23:0] trim_width(input logic [23:0] s, input logic [1:0] w);
    case (w)
      2'b01: trim_width = {s[23:4], 4'h0};
      2'b10: trim_width = {s[23:8], 8'h00};
      default: trim_width = s;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Control registers

  logic [9:0] dacCtrl1;
  logic [9:0] dacCtrl2;
  logic [9:0] dacVol [0:5];
  logic [9:0] adcCtrl1;
  logic [9:0] adcCtrl2;
  logic [9:0] adcCtrl3;
  logic [5:0] peak0;
  logic [5:0] peak1;
  logic [3:0] frameAddr;
  logic frameRead;
  logic writeOk;
  logic [11:0] scaleCount;
  logic scaleOpen;

  assign frameAddr = ctrlFrame[`FRAME_ADDR_HI -: 4];
  assign frameRead = ctrlFrame[`FRAME_RW_BIT];
  // Bit 10 set marks an illegal frame, ignored as a write
  assign writeOk = ctrlValid && !frameRead && !ctrlFrame[`FRAME_ZERO_BIT];

  always_ff @(posedge core_clk or negedge rst_n)
    if (!rst_n)
      scaleCount <= 12'h0;
    else if (scaleOpen)
      scaleCount <= scaleCount + 12'h1;

  assign scaleOpen = (scaleCount < 12'(`SCALE_WINDOW));

  always_ff @(posedge core_clk or negedge rst_n)
    if (!rst_n)
    begin
      dacCtrl1 <= `RESET_CTRL;
      dacCtrl2 <= `RESET_CTRL;
      adcCtrl1 <= `RESET_CTRL;
      adcCtrl2 <= `RESET_CTRL;
      adcCtrl3 <= `RESET_CTRL;
      for (int i = 0; i < 6; i++)
        dacVol[i] <= `RESET_VOL;
    end
    else if (writeOk)
    begin
      case (frameAddr)
        `ADDR_DAC_CTRL1: dacCtrl1 <= ctrlFrame[9:0];
        `ADDR_DAC_CTRL2: dacCtrl2 <= ctrlFrame[9:0];
        `ADDR_ADC_CTRL1: adcCtrl1 <= ctrlFrame[9:0];
        `ADDR_ADC_CTRL2: adcCtrl2 <= ctrlFrame[9:0];
        // Scaler bits only take effect inside the post-reset window
        `ADDR_ADC_CTRL3: adcCtrl3 <= scaleOpen ? ctrlFrame[9:0]
                                   : {ctrlFrame[9:2], adcCtrl3[1:0]};
        // Peak addresses fall to default: writes dropped
        default:
          if (frameAddr >= `ADDR_DAC_VOL0 && frameAddr < 4'(`ADDR_DAC_VOL0 + 6))
            dacVol[3'(frameAddr - `ADDR_DAC_VOL0)] <= ctrlFrame[9:0];
      endcase
    end

  ////////////////////////////////////////////////////////////////////////////
  // Readback; a peak read also clears it

  logic readPeak0;
  logic readPeak1;
  assign readPeak0 = ctrlValid && frameRead && frameAddr == `ADDR_ADC_PEAK0;
  assign readPeak1 = ctrlValid && frameRead && frameAddr == `ADDR_ADC_PEAK1;

  always_ff @(posedge core_clk or negedge rst_n)
    if (!rst_n)
    begin
      ctrlReadData <= 10'h000;
      ctrlReadValid <= 1'b0;
    end
    else
    begin
      ctrlReadValid <= ctrlValid && frameRead;
      if (ctrlValid && frameRead)
        case (frameAddr)
          `ADDR_DAC_CTRL1: ctrlReadData <= dacCtrl1;
          `ADDR_DAC_CTRL2: ctrlReadData <= dacCtrl2;
          `ADDR_ADC_PEAK0: ctrlReadData <= {4'h0, peak0};
          `ADDR_ADC_PEAK1: ctrlReadData <= {4'h0, peak1};
          `ADDR_ADC_CTRL1: ctrlReadData <= adcCtrl1;
          `ADDR_ADC_CTRL2: ctrlReadData <= adcCtrl2;
          `ADDR_ADC_CTRL3: ctrlReadData <= adcCtrl3;
          default:
            if (frameAddr >= `ADDR_DAC_VOL0 && frameAddr < 4'(`ADDR_DAC_VOL0 + 6))
              ctrlReadData <= dacVol[3'(frameAddr - `ADDR_DAC_VOL0)];
            else
              ctrlReadData <= 10'h000;
        endcase
    end

  ////////////////////////////////////////////////////////////////////////////
  // Clocking and rates

  dac_rate_type dacRate;
  scaler_type scaler;
  logic adcFast;
  assign dacRate = dac_rate_type'(dacCtrl1[`DAC_RATE_LO +: 2]);
  assign scaler = scaler_type'(adcCtrl3[`SCALER_LO +: 2]);
  assign adcFast = adcCtrl1[`ADC_RATE_BIT];

  always_ff @(posedge core_clk or negedge rst_n)
    if (!rst_n)
    begin
      interpRatio <= 4'd8;
      decimRatio <= 8'(`OSR_48K);
      clockScale <= 2'd0;
    end
    else
    begin
      case (dacRate)
        RATE_96K: interpRatio <= 4'd4;
        RATE_192K: interpRatio <= 4'd2;
        default: interpRatio <= 4'd8;
      endcase
      decimRatio <= adcFast ? 8'(`OSR_96K) : 8'(`OSR_48K);
      // Reserved scaler code falls back to x2, the safe default
      clockScale <= (scaler == SCALE_RSVD) ? 2'd0 : 2'(scaler);
    end

  // ADC clocks: frame = bit/64; bit clock period 8 or 4 core cycles,
  // giving frame period 512 or 256 core cycles
  logic [8:0] adcDiv;
  always_ff @(posedge core_clk or negedge rst_n)
    if (!rst_n)
      adcDiv <= 9'h0;
    else
      adcDiv <= adcDiv + (adcFast ? 9'd2 : 9'd1);

  // One counter drives both so they stay locked to the sample rate
  always_ff @(posedge core_clk or negedge rst_n)
    if (!rst_n)
    begin
      adc_bit_clock_o <= 1'b0;
      adc_frame_clock_o <= 1'b0;
    end
    else
    begin
      adc_bit_clock_o <= adcDiv[2];
      adc_frame_clock_o <= adcDiv[8];
    end

  // Low on the select pin makes the device master
  assign adc_bit_clock_oe = !masterSelect_n;
  assign adc_frame_clock_oe = !masterSelect_n;

  // Frame edges for init timing, from whichever side owns the clock
  logic frameNow;
  logic frameLast;
  logic frameEdge;
  assign frameNow = masterSelect_n ? adc_frame_clock_i : adc_frame_clock_o;
  always_ff @(posedge core_clk or negedge rst_n)
    if (!rst_n)
      frameLast <= 1'b0;
    else
      frameLast <= frameNow;
  assign frameEdge = frameNow && !frameLast;

  ////////////////////////////////////////////////////////////////////////////
  // Initialization

  core_state_type state;
  logic [4:0] initFrames;
  always_ff @(posedge core_clk or negedge rst_n)
    if (!rst_n)
    begin
      state <= INIT_CLEAR;
      initFrames <= 5'd0;
    end
    else
      case (state)
        INIT_CLEAR:
          if (frameEdge)
          begin
            initFrames <= initFrames + 5'd1;
            if (initFrames == 5'(`INIT_FRAMES - 1))
              state <= RUNNING;
          end
        RUNNING: state <= RUNNING;
        default: state <= INIT_CLEAR;
      endcase

  assign initBusy = (state == INIT_CLEAR);

  ////////////////////////////////////////////////////////////////////////////
  // Peak detectors, cleared by init and on read

  logic [5:0] sampleDb0;
  logic [5:0] sampleDb1;
  assign sampleDb0 = mag_to_db(magnitude(adcLeft));
  assign sampleDb1 = mag_to_db(magnitude(adcRight));

  // A sample in the read cycle starts the new peak, so no event is lost
  always_ff @(posedge core_clk or negedge rst_n)
    if (!rst_n)
    begin
      peak0 <= `PEAK_MIN;
      peak1 <= `PEAK_MIN;
    end
    else if (initBusy)
    begin
      peak0 <= `PEAK_MIN;
      peak1 <= `PEAK_MIN;
    end
    else
    begin
      if (readPeak0)
        peak0 <= adcSampleValid ? sampleDb0 : `PEAK_MIN;
      else if (adcSampleValid && sampleDb0 < peak0)
        peak0 <= sampleDb0;
      if (readPeak1)
        peak1 <= adcSampleValid ? sampleDb1 : `PEAK_MIN;
      else if (adcSampleValid && sampleDb1 < peak1)
        peak1 <= sampleDb1;
    end

  ////////////////////////////////////////////////////////////////////////////
  // DAC sample path

  // Channel code: 0..5 = pair*2 + right. Serial mode uses pairs 0..2 on three
  // inputs; packed mode carries all six on one input
  logic packedMode;
  logic replicate;
  logic acceptWord;
  logic [2:0] effChan;
  logic [23:0] trimmed;
  logic bufInValid;
  logic bufInReady;
  logic [23:0] bufData;
  logic [2:0] bufChan;
  logic [2:0] replStep;
  logic [2:0] outChan;
  logic popWord;

  assign packedMode = dacCtrl1[`DAC_PACKED_BIT];
  assign replicate = dacCtrl2[`DAC_REPL_BIT];
  // 192 kHz words beyond the first pair are dropped; packed not offered there
  assign acceptWord = !(dacRate == RATE_192K && (dacWordChan > 3'd1 || packedMode));
  assign effChan = dacWordChan;
  assign trimmed = trim_width(dacWord, dacCtrl1[`DAC_WIDTH_LO +: 2]);
  assign bufInValid = dacWordValid && !initBusy && acceptWord && dacWordChan < 3'd6;
  // Dropped words are consumed at once so the source never hangs
  assign dacWordReady = !initBusy && (bufInReady || !acceptWord || dacWordChan >= 3'd6);

  sample_buffer buffer
  (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .inValid(bufInValid),
    .inReady(bufInReady),
    .inData(trimmed),
    .inChan(effChan),
    .outValid(dacOutValid),
    .outReady(popWord),
    .outData(bufData),
    .outChan(bufChan)
  );

  // Replicate re-issues a first-pair word to pairs 1 and 2 before popping
  assign outChan = bufChan + replStep;
  assign popWord = dacOutReady && (!(replicate && bufChan < 3'd2) || replStep == 3'd4);

  always_ff @(posedge core_clk or negedge rst_n)
    if (!rst_n)
      replStep <= 3'd0;
    else if (dacOutValid && dacOutReady)
      replStep <= popWord ? 3'd0 : replStep + 3'd2;

  always_comb
  begin
    dacOutData = bufData;
    dacOutChan = outChan;
    dacOutGain = dacVol[outChan < 3'd6 ? outChan : 3'd0];
  end
endmodule

// [bench/codec_core_monitor.sv]
// Port checker for the codec digital core
`timescale 1ns/1ps
module codec_core_monitor (
  input wire logic core_clk,
  input wire logic powerdown_reset_n,
  input wire logic ctrlValid,
  input wire logic [15:0] ctrlFrame,
  input wire logic ctrlReadValid,
  input wire logic [9:0] ctrlReadData,
  input wire logic masterSelect_n,
  input wire logic adc_bit_clock_oe,
  input wire logic adc_frame_clock_oe,
  input wire logic dacWordValid,
  input wire logic dacWordReady,
  input wire logic [2:0] dacWordChan,
  input wire logic dacOutValid,
  input wire logic dacOutReady,
  input wire logic [23:0] dacOutData,
  input wire logic [2:0] dacOutChan,
  input wire logic [3:0] interpRatio,
  input wire logic [7:0] decimRatio,
  input wire logic [1:0] clockScale,
  input wire logic initBusy
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!powerdown_reset_n);
  ////////////////////////////////////////////////////////////////////////////////
  // Saturating age so late scaler writes can be told apart
  logic [11:0] age;
  always_ff @(posedge core_clk or negedge powerdown_reset_n)
  begin
    if (!powerdown_reset_n)
      age <= 12'h000;
    else if (age != 12'hC10)
      age <= age + 12'h001;
  end
  ////////////////////////////////////////////////////////////////////////////////
  sequence s_read;
    ctrlValid && ctrlFrame[11];
  endsequence
  sequence s_write(a);
    ctrlValid && !ctrlFrame[11] && !ctrlFrame[10] && ctrlFrame[15:12] == a;
  endsequence
  property p_read_answer;
    s_read |=> ctrlReadValid;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read frame not answered");
  property p_no_stray;
    !(ctrlValid && ctrlFrame[11]) |=> !ctrlReadValid;
  endproperty
  a_no_stray: assert property (p_no_stray) else $error("answer without read");
  property p_peak_width;
    s_read ##0 ctrlFrame[15:13] == 3'h5 |=> ctrlReadData[9:6] == 4'h0;
  endproperty
  a_peak_width: assert property (p_peak_width) else $error("peak wider than 6 bits");
  property p_rate_96;
    s_write(4'h0) ##0 ctrlFrame[1:0] == 2'h1 |-> ##[1:2] interpRatio == 4'h4;
  endproperty
  a_rate_96: assert property (p_rate_96) else $error("rate 01 not 4x");
  property p_rate_rsvd;
    s_write(4'h0) ##0 ctrlFrame[1:0] == 2'h3 |-> ##[1:2] interpRatio == 4'h8;
  endproperty
  a_rate_rsvd: assert property (p_rate_rsvd) else $error("rate 11 not 8x");
  property p_decim;
    s_write(4'hC) ##0 ctrlFrame[6] |-> ##[1:2] decimRatio == 8'h40;
  endproperty
  a_decim: assert property (p_decim) else $error("fast ADC rate not 64");
  property p_bad_frame;
    ctrlValid && !ctrlFrame[11] && ctrlFrame[10] |=> $stable(interpRatio) && $stable(clockScale);
  endproperty
  a_bad_frame: assert property (p_bad_frame) else $error("frame with bit 10 set applied");
  property p_late_scale;
    s_write(4'hE) ##0 age == 12'hC10 |=> $stable(clockScale);
  endproperty
  a_late_scale: assert property (p_late_scale) else $error("late scaler write applied");
  property p_master_pins;
    !masterSelect_n [*3] |-> adc_bit_clock_oe && adc_frame_clock_oe;
  endproperty
  a_master_pins: assert property (p_master_pins) else $error("master not driving clocks");
  property p_init_block;
    initBusy |-> !dacWordReady;
  endproperty
  a_init_block: assert property (p_init_block) else $error("word taken during init");
  property p_out_hold;
    dacOutValid && !dacOutReady |=> dacOutValid && $stable(dacOutData) && $stable(dacOutChan);
  endproperty
  a_out_hold: assert property (p_out_hold) else $error("stalled output changed");
  property p_accept;
    dacWordValid && dacWordReady && dacWordChan == 3'h0 |=> dacOutValid;
  endproperty
  a_accept: assert property (p_accept) else $error("pair 0 word lost");
endmodule
bind audio_codec_digital_core codec_core_monitor mon (.core_clk, .powerdown_reset_n, .ctrlValid, .ctrlFrame,
  .ctrlReadValid, .ctrlReadData, .masterSelect_n, .adc_bit_clock_oe, .adc_frame_clock_oe, .dacWordValid,
  .dacWordReady, .dacWordChan, .dacOutValid, .dacOutReady, .dacOutData, .dacOutChan, .interpRatio,
  .decimRatio, .clockScale, .initBusy);

// [bench/codec_host_model.sv]
// Controller model: DAC word source, output sink, slave ADC clocks
`timescale 1ns/1ps
module codec_host_model (
  input wire logic core_clk,
  input wire logic stall,
  output logic dacWordValid,
  input wire logic dacWordReady,
  output logic [23:0] dacWord,
  output logic [2:0] dacWordChan,
  input wire logic dacOutValid,
  output logic dacOutReady,
  input wire logic [23:0] dacOutData,
  input wire logic [2:0] dacOutChan,
  input wire logic [9:0] dacOutGain,
  output logic slaveBit,
  output logic slaveFrame
);
  logic [39:0] got[$];
  logic [9:0] tick = 10'h000;
  initial
  begin
    dacWordValid = 1'b0;
    dacWord = 24'h000000;
    dacWordChan = 3'h0;
    dacOutReady = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // One bit and one frame clock for both channels, 64 bits a frame
  always @(negedge core_clk)
    tick <= tick + 10'h001;
  assign slaveBit = tick[1];
  assign slaveFrame = tick[7];
  // Ready set first so the capture matches the coming edge
  always @(negedge core_clk)
  begin
    dacOutReady = !stall;
    if (dacOutValid && !stall)
      got.push_back({3'h0, dacOutChan, dacOutGain, dacOutData});
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Held until ready; data scrambled once released
  task automatic send(input logic [23:0] w, input logic [2:0] c);
    @(negedge core_clk);
    dacWordValid = 1'b1;
    dacWord = w;
    dacWordChan = c;
    // Ready depends on the channel; let it settle first
    #1;
    for (int i = 0; i < 100 && !dacWordReady; i++)
      @(negedge core_clk);
    @(negedge core_clk);
    dacWordValid = 1'b0;
    dacWord = ~w;
  endtask
endmodule

// [bench/test_audio_codec_digital_core.sv]
// Self-checking bench for the codec digital core
`timescale 1ns/1ps
module test_audio_codec_digital_core;
  logic core_clk = 1'b0;
  logic powerdown_reset_n = 1'b0;
  logic ctrlValid = 1'b0;
  logic masterSelect_n = 1'b0;
  logic adcSampleValid = 1'b0;
  logic stall = 1'b0;
  logic fr = 1'b0;
  logic bc = 1'b0;
  logic [15:0] ctrlFrame = 16'h0000;
  logic [23:0] adcLeft = 24'h000000, adcRight = 24'h000000, dacWord, dacOutData;
  logic [9:0] ctrlReadData, dacOutGain, rd;
  logic ctrlReadValid, adc_bit_clock_o, adc_bit_clock_oe, adc_frame_clock_o, adc_frame_clock_oe;
  logic dacWordValid, dacWordReady, dacOutValid, dacOutReady, initBusy, slaveBit, slaveFrame;
  logic [2:0] dacWordChan, dacOutChan;
  logic [3:0] interpRatio;
  logic [7:0] decimRatio;
  logic [1:0] clockScale;
  logic [3:0] ratio [4] = '{4'h8, 4'h4, 4'h2, 4'h8};
  int bad_count = 0, n_compared = 0, rises = 0, t0 = 0, per = 0, nb = 0, bits = 0;
  wire adc_bit_clock_i = adc_bit_clock_oe ? adc_bit_clock_o : slaveBit;
  wire adc_frame_clock_i = adc_frame_clock_oe ? adc_frame_clock_o : slaveFrame;
  always #50 core_clk = ~core_clk;
  audio_codec_digital_core DUT (.core_clk, .powerdown_reset_n, .ctrlValid, .ctrlFrame, .ctrlReadData,
    .ctrlReadValid, .masterSelect_n, .adc_bit_clock_o, .adc_bit_clock_oe, .adc_bit_clock_i, .adc_frame_clock_o,
    .adc_frame_clock_oe, .adc_frame_clock_i, .adcSampleValid, .adcLeft, .adcRight, .dacWordValid, .dacWordReady,
    .dacWord, .dacWordChan, .dacOutValid, .dacOutReady, .dacOutData, .dacOutChan, .dacOutGain, .interpRatio,
    .decimRatio, .clockScale, .initBusy);
  codec_host_model host (.core_clk, .stall, .dacWordValid, .dacWordReady, .dacWord, .dacWordChan, .dacOutValid,
    .dacOutReady, .dacOutData, .dacOutChan, .dacOutGain, .slaveBit, .slaveFrame);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [39:0] e, input logic [39:0] g);
    n_compared++;
    if (g !== e)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic ctrl(input logic [3:0] a, input logic r, input logic z, input logic [9:0] d);
    @(negedge core_clk);
    ctrlValid = 1'b1;
    ctrlFrame = {a, r, z, d};
    @(negedge core_clk);
    ctrlValid = 1'b0;
    ctrlFrame = ~ctrlFrame;
    rd = ctrlReadData;
    chk("answer", {39'h0, r}, {39'h0, ctrlReadValid});
    // Ratios are registered one edge after the control register
    @(negedge core_clk);
  endtask
  // Bounded wait for the sink to hold n words
  task automatic await(input int n);
    for (int i = 0; i < 200 && host.got.size() < n; i++)
      @(negedge core_clk);
    chk("words", n, host.got.size());
    if (host.got.size() < n)
      wrap_up();
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (10) @(posedge core_clk);
    @(negedge core_clk);
    powerdown_reset_n = 1'b1;
    chk("interp", 4'h8, interpRatio);
    chk("busy", 1'b1, initBusy);
    ctrl(4'h2, 1'b1, 1'b0, 10'h000);
    chk("volume", 10'h3FF, rd);
    ctrl(4'hE, 1'b0, 1'b0, 10'h002);
    chk("scale", 2'h2, clockScale);
    ctrl(4'hE, 1'b0, 1'b1, 10'h001);
    chk("scale", 2'h2, clockScale);
    ctrl(4'hE, 1'b0, 1'b0, 10'h001);
    chk("scale", 2'h1, clockScale);
    for (int i = 0; i < 4; i++)
    begin
      ctrl(4'h0, 1'b0, 1'b0, 10'(i));
      chk("interp", ratio[i], interpRatio);
    end
    ctrl(4'h0, 1'b0, 1'b0, 10'h000);
    // Busy must end after twenty master frame clocks of 512 cycles
    for (int i = 0; i < 12000 && initBusy; i++)
    begin
      @(negedge core_clk);
      if (adc_bit_clock_o && !bc)
        nb++;
      bc = adc_bit_clock_o;
      if (adc_frame_clock_o && !fr)
      begin
        rises++;
        per = i - t0;
        t0 = i;
        bits = nb;
        nb = 0;
      end
      fr = adc_frame_clock_o;
    end
    chk("frames", 20, rises);
    chk("period", 512, per);
    chk("bits", 64, bits);
    chk("busy", 1'b0, initBusy);
    if (initBusy)
      wrap_up();
    ctrl(4'hE, 1'b0, 1'b0, 10'h000);
    chk("late scale", 2'h1, clockScale);
    ctrl(4'hC, 1'b0, 1'b0, 10'h040);
    chk("decim", 8'h40, decimRatio);
    ctrl(4'hC, 1'b0, 1'b0, 10'h000);
    chk("decim", 8'h80, decimRatio);
    @(negedge core_clk);
    adcSampleValid = 1'b1;
    adcLeft = 24'h7FFFFF;
    adcRight = 24'h000001;
    @(negedge core_clk);
    adcSampleValid = 1'b0;
    adcLeft = 24'h800000;
    ctrl(4'hA, 1'b1, 1'b0, 10'h000);
    chk("peak0", 6'h00, rd);
    ctrl(4'hA, 1'b0, 1'b0, 10'h000);
    ctrl(4'hA, 1'b1, 1'b0, 10'h000);
    chk("peak0", 6'h3F, rd);
    ctrl(4'hB, 1'b1, 1'b0, 10'h000);
    chk("peak1", 6'h3F, rd);
    ctrl(4'h4, 1'b0, 1'b0, 10'h155);
    host.send(24'h123456, 3'h2);
    await(1);
    chk("gain", {6'h2, 10'h155, 24'h123456}, host.got[0]);
    ctrl(4'h1, 1'b0, 1'b0, 10'h002);
    host.send(24'hABCDEF, 3'h0);
    await(4);
    chk("copy", {6'h0, 10'h3FF, 24'hABCDEF}, host.got[1]);
    chk("copy", {6'h2, 10'h155, 24'hABCDEF}, host.got[2]);
    chk("copy", {6'h4, 10'h3FF, 24'hABCDEF}, host.got[3]);
    ctrl(4'h1, 1'b0, 1'b0, 10'h000);
    stall <= 1'b1;
    host.send(24'h000011, 3'h1);
    host.send(24'hFFFFEE, 3'h5);
    chk("full", 1'b0, dacWordReady);
    stall <= 1'b0;
    await(6);
    chk("order", {6'h5, 10'h3FF, 24'hFFFFEE}, host.got[5]);
    ctrl(4'h0, 1'b0, 1'b0, 10'h002);
    host.send(24'h0000AA, 3'h3);
    host.send(24'h0000BB, 3'h6);
    host.send(24'h0000CC, 3'h1);
    await(7);
    chk("pair0 only", {6'h1, 10'h3FF, 24'h0000CC}, host.got[6]);
    ctrl(4'h0, 1'b0, 1'b0, 10'h030);
    host.send(24'h123456, 3'h3);
    await(8);
    chk("width", {6'h3, 10'h3FF, 24'h123400}, host.got[7]);
    masterSelect_n = 1'b1;
    repeat (3) @(negedge core_clk);
    chk("slave", 2'h0, {adc_bit_clock_oe, adc_frame_clock_oe});
    // Second reset in mid-run must restore the default volume
    @(negedge core_clk);
    powerdown_reset_n = 1'b0;
    @(negedge core_clk);
    powerdown_reset_n = 1'b1;
    chk("busy", 1'b1, initBusy);
    ctrl(4'h4, 1'b1, 1'b0, 10'h000);
    chk("volume", 10'h3FF, rd);
    wrap_up();
  end
endmodule
